/* common/lattice_pkg.sv */
package lattice_pkg;
	// ======================================================
	// widths
	localparam int K_W        = 10;
	localparam int V_W        = 14;
	localparam int DAC_W      = 8;
	localparam int SECTIONS   = 10;
	localparam int STATES     = 20;
	localparam int STACK_LEVELS = 8;
	// ======================================================
	// timing
	localparam int CLK_NS        = 5;
	localparam int STATE_NS_FAST = 5000;
	localparam int STATE_NS_SLOW = 6250;
	localparam int STATE_CYC_FAST = (STATE_NS_FAST + CLK_NS - 1) / CLK_NS;
	localparam int STATE_CYC_SLOW = (STATE_NS_SLOW + CLK_NS - 1) / CLK_NS;
	// ======================================================
	// state time slots
	localparam logic [4:0] T_B2      = 5'h08;
	localparam logic [4:0] T_Y10     = 5'h09;
	localparam logic [4:0] T_Y9      = 5'h0A;
	localparam logic [4:0] T_SCALE_M = 5'h0B;
	localparam logic [4:0] T_Y1      = 5'h12;
	localparam logic [4:0] T_SCALE_A = 5'h13;
	localparam logic [4:0] T_LAST    = 5'h14;
	// ======================================================
	// converter codes
	localparam logic [7:0] DAC_FULL_ON  = 8'hFF;
	localparam logic [7:0] DAC_FULL_OFF = 8'h00;
	localparam logic [9:0] LATCH_REST   = 10'h3FF;
	localparam logic [13:0] V_ZERO      = 14'h0000;
	typedef enum logic [1:0] {
		PH_IDLE = 2'b01,
		PH_RUN  = 2'b10
	} phase_t;
endpackage

/* rtl/dac_encoder.sv */
`timescale 1ns/1ps
module dac_encoder
	import lattice_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	input  wire logic       load_i,
	input  wire logic [9:0] latch_i,
	output logic      [7:0] dac_code_o
);
	logic latch_sign_bit;
	logic latch_overflow_hi;
	logic latch_overflow_lo;
	logic [6:0] latch_magnitude_bits;
	logic [7:0] code_next;
	assign latch_sign_bit       = latch_i[9];
	assign latch_overflow_hi    = latch_i[8];
	assign latch_overflow_lo    = latch_i[7];
	assign latch_magnitude_bits = latch_i[6:0];
	always_comb begin
		if (!latch_sign_bit && (latch_overflow_hi || latch_overflow_lo)) begin
			code_next = DAC_FULL_ON;
		end else if (latch_sign_bit && !(latch_overflow_hi && latch_overflow_lo)) begin
			code_next = DAC_FULL_OFF;
		end else begin
			code_next = {~latch_sign_bit, latch_magnitude_bits};
		end
	end
	// resting code after reset matches the idle latch
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dac_code_o <= 8'h7F;
		end else if (load_i) begin
			dac_code_o <= code_next;
		end
	end
endmodule

/* rtl/lattice_filter_dac_output.sv */
`timescale 1ns/1ps
module lattice_filter_dac_output
	import lattice_pkg::*;
#(
	parameter int STATE_CYC_10K = STATE_CYC_FAST,
	parameter int STATE_CYC_8K  = STATE_CYC_SLOW
)(
	input  wire logic                   clk_i,
	input  wire logic                   nrst_i,
	input  wire logic                   speaking_i,
	input  wire logic                   slow_rate_i,
	input  wire logic [SECTIONS*K_W-1:0] k_i,
	input  wire logic [V_W-1:0]         excite_i,
	input  wire logic [K_W-1:0]         excite_gain_i,
	output logic      [4:0]             state_time_o,
	output logic                        sample_strobe_o,
	output logic      [V_W-1:0]         filter_out_o,
	output logic      [DAC_W-1:0]       dac_code_o
);
	// the 12-bit divider cannot count past 4096 cycles per slot
	if (STATE_CYC_10K < 1 || STATE_CYC_8K < 1 ||
		STATE_CYC_10K > 4096 || STATE_CYC_8K > 4096) begin : g_bad_cycles
		$error("state time cycle count out of range");
	end
	// ======================================================
	// state time divider
	logic [11:0] div_reg;
	logic        tick;
	logic [11:0] div_top;
	phase_t      phase_reg;
	assign div_top = slow_rate_i ? 12'(STATE_CYC_8K - 1) : 12'(STATE_CYC_10K - 1);
	assign tick    = (div_reg >= div_top);
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			div_reg <= 12'h000;
		end else if (tick) begin
			div_reg <= 12'h000;
		end else begin
			div_reg <= div_reg + 12'h001;
		end
	end
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_time_o <= 5'h01;
		end else if (tick) begin
			state_time_o <= (state_time_o == T_LAST) ? 5'h01 : state_time_o + 5'h01;
		end
	end
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			phase_reg <= PH_IDLE;
		end else if (tick && state_time_o == T_LAST) begin
			case (phase_reg)
				PH_IDLE: phase_reg <= speaking_i ? PH_RUN : PH_IDLE;
				PH_RUN:  phase_reg <= speaking_i ? PH_RUN : PH_IDLE;
				default: phase_reg <= PH_IDLE;
			endcase
		end
	end
	// ======================================================
	// arithmetic
	// the schedule is evaluated per sample in equation order rather than
	// bit-serially; values match the slot table at each sample boundary
	logic signed [V_W-1:0] y_reg   [SECTIONS+1];
	logic signed [V_W-1:0] b_reg   [SECTIONS+1];
	logic signed [V_W-1:0] u_reg;
	logic signed [V_W-1:0] y_prev1_reg;
	function automatic logic signed [V_W-1:0] kmul(input logic [K_W-1:0] k,
	                                              input logic signed [V_W-1:0] v);
		logic signed [V_W+K_W-1:0] p;
		p = $signed(k) * v;
		return {p[V_W+K_W-2:K_W], 1'b1};
	endfunction
	function automatic logic [K_W-1:0] kof(input int n);
		return k_i[(n-1)*K_W +: K_W];
	endfunction
	logic signed [V_W-1:0] acc_reg;
	logic [3:0]            sec;
	always_comb begin
		sec = 4'h0;
		if (state_time_o >= T_Y10 && state_time_o <= T_Y1) begin
			sec = 4'(5'd19 - state_time_o);
		end else if (state_time_o <= T_B2) begin
			sec = 4'(5'd9 - state_time_o);
		end else if (state_time_o == T_LAST) begin
			sec = 4'h9;
		end
	end
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			y_prev1_reg <= V_ZERO;
			for (int i = 0; i <= SECTIONS; i++) begin
				y_reg[i] <= V_ZERO;
				b_reg[i] <= V_ZERO;
			end
		end else if (tick) begin
			if (phase_reg == PH_IDLE) begin
				// old Y1 must not leak into the next phrase
				y_prev1_reg <= V_ZERO;
				for (int i = 0; i <= SECTIONS; i++) begin
					y_reg[i] <= V_ZERO;
					b_reg[i] <= V_ZERO;
				end
			end else if (state_time_o == T_Y10) begin
				y_reg[10] <= u_reg - kmul(kof(10), b_reg[10]);
			end else if (state_time_o == T_Y9) begin
				y_reg[9] <= y_reg[10] - kmul(kof(9), b_reg[9]);
			end else if (state_time_o > T_Y9 && state_time_o < T_Y1) begin
				y_reg[sec] <= y_reg[sec+1] - kmul(kof(sec), b_reg[sec]);
			end else if (state_time_o == T_Y1) begin
				y_reg[1]    <= y_reg[2] - kmul(kof(1), y_prev1_reg);
			end else if (state_time_o == T_B2) begin
				// b2 from old Y1 and current Y1
				b_reg[2]    <= y_prev1_reg + kmul(kof(1), y_reg[1]);
				b_reg[1]    <= y_reg[1];
				y_prev1_reg <= y_reg[1];
			end else if (state_time_o == T_LAST || state_time_o < T_B2) begin
				b_reg[sec+1] <= b_reg[sec] + kmul(kof(sec), y_reg[sec]);
			end
		end
	end
	// own process: slot 11 must still form Y8 in the chain above
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			acc_reg <= V_ZERO;
			u_reg   <= V_ZERO;
		end else if (tick) begin
			if (phase_reg == PH_IDLE) begin
				acc_reg <= V_ZERO;
				u_reg   <= V_ZERO;
			end else if (state_time_o == T_SCALE_M) begin
				acc_reg <= kmul(excite_gain_i, excite_i);
			end else if (state_time_o == T_SCALE_A) begin
				// scaled word stored for slot 9
				u_reg <= acc_reg;
			end
		end
	end
	// ======================================================
	// output latch
	logic [9:0] latch_reg;
	logic       load_pulse;
	assign load_pulse      = tick && (state_time_o == T_SCALE_A);
	assign sample_strobe_o = load_pulse;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			latch_reg    <= LATCH_REST;
			filter_out_o <= V_ZERO;
		end else if (load_pulse) begin
			// idle latch rests at minus one
			if (phase_reg == PH_IDLE) begin
				latch_reg    <= LATCH_REST;
				filter_out_o <= V_ZERO;
			end else begin
				latch_reg    <= y_reg[1][V_W-1:V_W-10];
				filter_out_o <= y_reg[1];
			end
		end
	end
	logic load_d_reg;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			load_d_reg <= 1'b0;
		end else begin
			load_d_reg <= load_pulse;
		end
	end
	dac_encoder u_enc (
		.clk_i      (clk_i),
		.nrst_i     (nrst_i),
		.load_i     (load_d_reg),
		.latch_i    (latch_reg),
		.dac_code_o (dac_code_o)
	);
endmodule

/* verif/dac_current_model.sv */
`timescale 1ns/1ps
module dac_current_model
	import lattice_pkg::*;
(
	input  wire logic [DAC_W-1:0] code_i,
	output int                    sink_lsb_o
);
	// sink in converter steps: all ones draws nothing
	assign sink_lsb_o = 255 - int'(code_i);
endmodule

/* verif/lattice_asserts.sv */
`timescale 1ns/1ps
module lattice_asserts
	import lattice_pkg::*;
#(
	parameter int STATE_CYC_10K = 2,
	parameter int STATE_CYC_8K  = 3
)(
	input wire logic             clk_i,
	input wire logic             nrst_i,
	input wire logic             slow_rate_i,
	input wire logic [4:0]       state_time_o,
	input wire logic             sample_strobe_o,
	input wire logic [V_W-1:0]   filter_out_o,
	input wire logic [DAC_W-1:0] dac_code_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// =====
	// sample spacing; first strobe after reset has no reference
	int   gap_reg;
	logic seen_reg;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			gap_reg  <= 1;
			seen_reg <= 1'b0;
		end else if (sample_strobe_o) begin
			gap_reg  <= 1;
			seen_reg <= 1'b1;
		end else begin
			gap_reg <= gap_reg + 1;
		end
	end
	chk_strobe_pulse: assert property (sample_strobe_o |=> !sample_strobe_o)
		else $error("strobe longer than one cycle");
	chk_strobe_slot: assert property (sample_strobe_o |-> state_time_o == T_SCALE_A)
		else $error("strobe outside slot 19");
	chk_sample_period: assert property (sample_strobe_o && seen_reg |->
		gap_reg == 20 * (slow_rate_i ? STATE_CYC_8K : STATE_CYC_10K))
		else $error("sample period wrong");
	chk_slot_order: assert property ($changed(state_time_o) |-> state_time_o ==
		(($past(state_time_o) == T_LAST) ? 5'h01 : $past(state_time_o) + 5'h01))
		else $error("slot order broken");
	chk_slot_hold: assert property ($changed(state_time_o) |=> $stable(state_time_o))
		else $error("slot too short");
	chk_code_timing: assert property ($changed(dac_code_o) |-> $past(sample_strobe_o, 2))
		else $error("code changed off schedule");
	chk_clip_high: assert property ($past(sample_strobe_o, 2) && !filter_out_o[13]
		&& |filter_out_o[12:11] |-> dac_code_o == DAC_FULL_ON)
		else $error("positive clip missing");
	chk_clip_low: assert property ($past(sample_strobe_o, 2) && filter_out_o[13]
		&& !(&filter_out_o[12:11]) |-> dac_code_o == DAC_FULL_OFF)
		else $error("negative clip missing");
	chk_negative_code: assert property ($past(sample_strobe_o, 2) &&
		&filter_out_o[13:11] |-> dac_code_o == {1'b0, filter_out_o[10:4]})
		else $error("in range code wrong");
endmodule
bind lattice_filter_dac_output lattice_asserts #(
	.STATE_CYC_10K(STATE_CYC_10K),
	.STATE_CYC_8K(STATE_CYC_8K)
) u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .slow_rate_i(slow_rate_i),
	.state_time_o(state_time_o), .sample_strobe_o(sample_strobe_o),
	.filter_out_o(filter_out_o), .dac_code_o(dac_code_o));

/* verif/lattice_filter_dac_output_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end
module lattice_filter_dac_output_tb;
	import lattice_pkg::*;
	logic                     clk_i, nrst_i, speaking_i, slow_rate_i;
	logic [SECTIONS*K_W-1:0]  k_i;
	logic [V_W-1:0]           excite_i, filter_out_o;
	logic [K_W-1:0]           excite_gain_i;
	logic [4:0]               state_time_o;
	logic                     sample_strobe_o;
	logic [DAC_W-1:0]         dac_code_o;
	logic [15:0]              lfsr;
	int                       n_fail, checks, sink;
	lattice_filter_dac_output #(.STATE_CYC_10K(2), .STATE_CYC_8K(3)) uut (
		.clk_i(clk_i), .nrst_i(nrst_i), .speaking_i(speaking_i),
		.slow_rate_i(slow_rate_i), .k_i(k_i), .excite_i(excite_i),
		.excite_gain_i(excite_gain_i), .state_time_o(state_time_o),
		.sample_strobe_o(sample_strobe_o), .filter_out_o(filter_out_o),
		.dac_code_o(dac_code_o));
	dac_current_model dac (.code_i(dac_code_o), .sink_lsb_o(sink));
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// =====
	// model: with all K zero each product is the forced one
	function automatic logic [15:0] lfsr_next(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic logic [7:0] enc(input logic [9:0] l);
		if (!l[9] && |l[8:7]) return 8'hFF;
		if (l[9] && !(&l[8:7])) return 8'h00;
		return {~l[9], l[6:0]};
	endfunction
	function automatic int w14(input int x);
		return int'($signed(14'(x)));
	endfunction
	// product with the forced one, wrapped to the value width
	function automatic int mul(input logic [K_W-1:0] k, input int v);
		return w14(((int'($signed(k)) * v) >>> 9) | 1);
	endfunction
	task automatic end_sim();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic apply(input logic spk, input logic [13:0] e, input logic [9:0] g);
		int y, got, k;
		logic [13:0] yv;
		@(posedge clk_i);
		speaking_i <= spk;
		excite_i <= e;
		excite_gain_i <= g;
		got = 0;
		// three samples: scaled word lags one sample behind
		for (k = 0; k < 400 && got < 3; k++) begin
			@(negedge clk_i);
			if (sample_strobe_o === 1'b1) got++;
		end
		if (got < 3) n_fail++;
		repeat (2) @(negedge clk_i);
		y = ((int'($signed(g)) * int'($signed(e))) >>> 9) | 1;
		yv = spk ? 14'(y - 10) : V_ZERO;
		`CHK(filter_out_o, yv)
		`CHK(dac_code_o, enc(spk ? yv[13:4] : 10'h3FF))
	endtask
	// nonzero K: b path and delay stack reach the output
	task automatic lattice_run();
		int                      y[11];
		int                      b[11];
		int                      u, s, j;
		logic [13:0]             yv, e;
		logic [9:0]              g;
		logic [SECTIONS*K_W-1:0] kv;
		for (j = 0; j < SECTIONS; j++) begin
			lfsr = lfsr_next(lfsr);
			kv[j*K_W +: K_W] = lfsr[9:0];
		end
		lfsr = lfsr_next(lfsr);
		e = lfsr[13:0];
		g = lfsr[15:6];
		// idle leaves Y zero, so the first b pass adds only the forced ones
		for (j = 0; j <= SECTIONS; j++) b[j] = (j >= 2 && j <= 9) ? 1 : 0;
		u = 0;
		while (sample_strobe_o !== 1'b1) @(negedge clk_i);
		@(posedge clk_i);
		speaking_i    <= 1'b1;
		excite_i      <= e;
		excite_gain_i <= g;
		k_i           <= kv;
		for (s = 0; s < 6; s++) begin
			@(negedge clk_i);
			while (sample_strobe_o !== 1'b1) @(negedge clk_i);
			y[10] = w14(u - mul(kv[9*K_W +: K_W], b[10]));
			for (j = 9; j >= 1; j--) y[j] = w14(y[j+1] - mul(kv[(j-1)*K_W +: K_W], b[j]));
			yv = 14'(y[1]);
			@(negedge clk_i);
			`CHK(filter_out_o, yv)
			@(negedge clk_i);
			`CHK(dac_code_o, enc(yv[13:4]))
			for (j = 9; j >= 1; j--) b[j+1] = w14(b[j] + mul(kv[(j-1)*K_W +: K_W], y[j]));
			b[1] = y[1];
			u = mul(g, int'($signed(e)));
		end
		@(posedge clk_i);
		speaking_i <= 1'b0;
		k_i        <= '0;
	endtask
	initial begin
		nrst_i = 1'b0;
		speaking_i = 1'b0;
		slow_rate_i = 1'b0;
		k_i = '0;
		excite_i = '0;
		excite_gain_i = '0;
		lfsr = 16'h6050;
		for (int r = 0; r < 2; r++) begin
			@(posedge clk_i);
			nrst_i <= 1'b0;
			slow_rate_i <= r[0];
			repeat (6) @(posedge clk_i);
			nrst_i <= 1'b1;
			apply(1'b0, 14'h1234, 10'h155);
			`CHK(sink, 128)
			apply(1'b1, 14'h0100, 10'h100);
			apply(1'b1, 14'h3F00, 10'h100);
			for (int i = 0; i < 8; i++) begin
				lfsr = lfsr_next(lfsr);
				apply(1'b1, lfsr[13:0], lfsr[15:6]);
			end
			apply(1'b0, lfsr[13:0], lfsr[9:0]);
			lattice_run();
		end
		end_sim();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		end_sim();
	end
endmodule
